// >>> verilog/bsc_pkg.sv
// What this block does
// - peak current target = (base + step*code) * (1 + 0.4*(trim-63)/63), 7-bit trim
// - low output voltage: off period ends when zero-cross comparator fires
// - low-side switch waits for high-side gate threshold comparator before turning on
// - continuous mode: low side turns on at gate threshold, with or without zero-cross
// - each overcurrent period increments counter up to count limit plus one
// - overcurrent counter clears when channel disabled and at each dimming cycle start
// - at count limit plus one channel stays off until flag read, then resumes
// - switch-node overvoltage comparator forces the high-side switch on
// - low-side driver enable 0 holds the low-side driver output low
// - discontinuous, no-limit 0: low side off at zero-cross until off period ends
// - discontinuous, no-limit 1: low side stays on until off period ends
// - low output active: keep bit 0 turns low side off now, 1 acts normally
// - adaptive non-overlap: high side on at low-side gate threshold, low-side on-time limit tuned but not applied
// - adaptive: late low-side turn-off extends that one off period
// - fixed non-overlap: fraction of off period, at least one cycle; off period never extended
// - lead/follow: channel two off phase starts at channel one peak, off follows one
// - lead/follow: fixed non-overlap on channel two forced to adaptive code 01
// - channel enable follows dim input delayed about 5.5 us on both edges
// - range select change applies only after new threshold code is applied
package bsc_pkg;
	localparam int          CLK_MHZ        = 250;
	localparam int          DIM_DELAY_NS   = 5500;
	localparam int          DIM_DELAY_CYC  = (DIM_DELAY_NS * CLK_MHZ) / 1000;
	localparam int          TOFF_W         = 12;
	localparam int          TRIM_W         = 7;
	localparam logic [6:0]  TRIM_MID       = 7'h3f;
	localparam int          TRIM_GAIN_NUM  = 4;
	localparam int          TRIM_GAIN_DEN  = 630;
	localparam int          THR_W          = 9;
	localparam int          RNG_W          = 3;
	localparam int          CUR_W          = 24;
	localparam int          NOV_FRAC_SH    = 3;
	localparam logic [1:0]  NOV_ADAPT_01   = 2'h1;
	localparam logic [1:0]  OC_LIM_RST     = 2'h3;

	typedef struct packed {
		logic               ls_drv_en;
		logic               rev_no_limit;
		logic               low_out_keep;
		logic [1:0]         nov_sel;
		logic [1:0]         oc_limit;
		logic [TOFF_W-1:0]  toff_cyc;
	} bsc_cfg_s;

	typedef struct packed {
		logic zero_cross;
		logic hs_gate_thr;
		logic ls_gate_thr;
		logic peak_reached;
		logic overcurrent;
		logic sw_overvolt;
		logic low_out_active;
	} bsc_cmp_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ON   = 2'b01,
		ST_OFF  = 2'b10,
		ST_NOV  = 2'b11
	} bsc_state_e;
endpackage

// >>> verilog/bsc_dim_delay.sv
`timescale 1ns/1ns
module bsc_dim_delay #(
	parameter int DELAY_CYC = 1375
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic dim_i,
	output logic      dim_o
);
	localparam int CW = $clog2(DELAY_CYC + 1);
	logic [CW-1:0] cnt_r;
	logic          tgt_r;

	// one timer restarted by each edge; same count both ways keeps duty intact
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
			tgt_r <= 1'b0;
			dim_o <= 1'b0;
		end else if (dim_i != tgt_r) begin
			tgt_r <= dim_i;
			cnt_r <= CW'(DELAY_CYC - 1);
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end else begin
			dim_o <= tgt_r;
		end
	end
endmodule

// >>> verilog/bsc_top.sv
`timescale 1ns/1ns
module bsc_top #(
	parameter int NCH       = 2,
	parameter int DELAY_CYC = bsc_pkg::DIM_DELAY_CYC
) (
	input  wire logic                          clk_sys_i,
	input  wire logic                          rstn_i,
	input  wire logic [NCH-1:0]                chan_en_i,
	input  wire logic [NCH-1:0]                dim_input_i,
	input  wire logic                          lead_follow_i,
	input  wire bsc_pkg::bsc_cfg_s [NCH-1:0]   cfg_i,
	input  wire bsc_pkg::bsc_cmp_s [NCH-1:0]   cmp_i,
	input  wire logic [NCH-1:0][6:0]           peak_current_trim_i,
	input  wire logic [NCH-1:0][8:0]           peak_threshold_code_i,
	input  wire logic [NCH-1:0][2:0]           peak_range_select_i,
	input  wire logic [NCH-1:0]                thr_write_i,
	input  wire logic [NCH-1:0][23:0]          range_base_i,
	input  wire logic [NCH-1:0][15:0]          range_step_i,
	input  wire logic [NCH-1:0]                oc_flag_read_i,
	output logic [NCH-1:0]                     hs_on_o,
	output logic [NCH-1:0]                     ls_on_o,
	output logic [NCH-1:0]                     overcurrent_flag_o,
	output logic [NCH-1:0]                     chan_active_o,
	output logic [NCH-1:0][2:0]                range_applied_o,
	output logic [NCH-1:0][23:0]               peak_target_o
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	function automatic logic is_fixed(input logic [1:0] sel);
		is_fixed = sel[1];
	endfunction

	// lead channel timing shared with follower
	logic lead_peak;
	logic lead_off_end;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic                        dim_dly;
			logic                        dim_prev_r;
			bsc_pkg::bsc_state_e         st_r;
			bsc_pkg::bsc_state_e         st_nxt;
			logic [bsc_pkg::TOFF_W-1:0]  toff_cnt_r;
			logic [bsc_pkg::TOFF_W-1:0]  nov_cnt_r;
			logic [bsc_pkg::TOFF_W-1:0]  ls_on_lim_r;
			logic [2:0]                  oc_cnt_r;
			logic                        oc_latched_r;
			logic                        oc_seen_r;
			logic                        ls_r;
			logic                        ls_blk_r;
			logic                        ext_r;
			logic                        ext_req;
			logic [1:0]                  nov_eff;
			logic                        follower;
			logic                        run;
			logic                        toff_done;
			logic [2:0]                  rng_pend_r;
			logic                        rng_wait_r;
			logic signed [8:0]           trim_d;
			logic [39:0]                 base_i;
			logic signed [49:0]          scaled;

			bsc_dim_delay #(.DELAY_CYC(DELAY_CYC)) u_dly (
				.clk_sys_i (clk_sys_i),
				.rst_n_i   (rst_n),
				.dim_i     (dim_input_i[g]),
				.dim_o     (dim_dly)
			);

			assign follower = lead_follow_i && (g == 1);
			assign nov_eff  = (follower && is_fixed(cfg_i[g].nov_sel)) ?
				bsc_pkg::NOV_ADAPT_01 : cfg_i[g].nov_sel;
			assign run      = chan_en_i[g] && dim_dly && !oc_latched_r;
			assign chan_active_o[g] = run;
			assign overcurrent_flag_o[g] = oc_latched_r;

			// ------------------------------------------------------------
			// peak current target
			// ------------------------------------------------------------
			always_ff @(posedge clk_sys_i or negedge rst_n) begin
				if (!rst_n) begin
					rng_pend_r <= 3'h0;
					rng_wait_r <= 1'b0;
					range_applied_o[g] <= 3'h0;
				end else if (peak_range_select_i[g] != rng_pend_r) begin
					rng_pend_r <= peak_range_select_i[g];
					rng_wait_r <= 1'b1;
				end else if (rng_wait_r && thr_write_i[g]) begin
					range_applied_o[g] <= rng_pend_r;
					rng_wait_r <= 1'b0;
				end
			end

			assign trim_d = $signed({2'b00, peak_current_trim_i[g]}) -
				$signed({2'b00, bsc_pkg::TRIM_MID});
			assign base_i = 40'(range_base_i[g]) +
				40'(range_step_i[g]) * 40'(peak_threshold_code_i[g]);
			// base*(1 + 0.4*d/63) = base + base*4*d/630
			assign scaled = $signed({10'h000, base_i}) +
				($signed({10'h000, base_i}) * 50'(trim_d) * 50'(bsc_pkg::TRIM_GAIN_NUM))
				/ 50'(bsc_pkg::TRIM_GAIN_DEN);
			always_ff @(posedge clk_sys_i or negedge rst_n) begin
				if (!rst_n)
					peak_target_o[g] <= 24'h000000;
				else
					peak_target_o[g] <= scaled[23:0];
			end

			// ------------------------------------------------------------
			// switching sequence
			// ------------------------------------------------------------
			assign toff_done = follower ? lead_off_end :
				(toff_cnt_r == '0) || (cmp_i[g].low_out_active && cmp_i[g].zero_cross);
			// one extra off cycle when the low side is still on at the end of the off time
			assign ext_req = !is_fixed(nov_eff) && !ext_r && ls_r && !cmp_i[g].ls_gate_thr;

			always_comb begin
				st_nxt = st_r;
				case (st_r)
					bsc_pkg::ST_IDLE: if (run && !follower) st_nxt = bsc_pkg::ST_ON;
						else if (run && lead_peak) st_nxt = bsc_pkg::ST_ON;
					bsc_pkg::ST_ON: if (!run) st_nxt = bsc_pkg::ST_IDLE;
						else if (follower ? lead_peak : cmp_i[g].peak_reached)
							st_nxt = bsc_pkg::ST_OFF;
					bsc_pkg::ST_OFF: if (!run) st_nxt = bsc_pkg::ST_IDLE;
						else if (toff_done && !ext_req) st_nxt = bsc_pkg::ST_NOV;
					bsc_pkg::ST_NOV: if (!run) st_nxt = bsc_pkg::ST_IDLE;
						else if (is_fixed(nov_eff) ? (nov_cnt_r == '0)
							: (!ls_r || cmp_i[g].ls_gate_thr)) st_nxt = bsc_pkg::ST_ON;
					default: st_nxt = bsc_pkg::ST_IDLE;
				endcase
			end

			always_ff @(posedge clk_sys_i or negedge rst_n) begin
				if (!rst_n) begin
					st_r       <= bsc_pkg::ST_IDLE;
					toff_cnt_r <= '0;
					nov_cnt_r  <= '0;
				end else begin
					st_r <= st_nxt;
					if (st_nxt == bsc_pkg::ST_OFF && st_r != bsc_pkg::ST_OFF)
						toff_cnt_r <= cfg_i[g].toff_cyc;
					else if (toff_cnt_r != '0)
						toff_cnt_r <= toff_cnt_r - 1'b1;
					// fixed gap is a fraction of off time, at least one cycle
					if (st_nxt == bsc_pkg::ST_NOV && st_r != bsc_pkg::ST_NOV)
						nov_cnt_r <= (cfg_i[g].toff_cyc >> bsc_pkg::NOV_FRAC_SH) | 1'b1;
					else if (nov_cnt_r != '0 && !(ls_r && !cmp_i[g].ls_gate_thr))
						nov_cnt_r <= nov_cnt_r - 1'b1;
				end
			end

			// adaptive: low-side on-time limit tuned per period
			always_ff @(posedge clk_sys_i or negedge rst_n) begin
				if (!rst_n) begin
					ls_on_lim_r <= '0;
					ext_r       <= 1'b0;
				end else if (st_r == bsc_pkg::ST_ON && st_nxt == bsc_pkg::ST_OFF) begin
					ext_r <= 1'b0;
				end else if (st_r == bsc_pkg::ST_NOV && st_nxt == bsc_pkg::ST_ON &&
						!is_fixed(nov_eff)) begin
					if (ls_r && ls_on_lim_r != '0)
						ls_on_lim_r <= ls_on_lim_r - 1'b1;
					else if (!ls_r && ls_on_lim_r != cfg_i[g].toff_cyc)
						ls_on_lim_r <= ls_on_lim_r + 1'b1;
				end else if (st_r == bsc_pkg::ST_OFF && !is_fixed(nov_eff)) begin
					// low side still on past the balanced point holds the off phase
					if (toff_done && ext_req)
						ext_r <= 1'b1;
				end
			end

			// ------------------------------------------------------------
			// drivers
			// ------------------------------------------------------------
			always_ff @(posedge clk_sys_i or negedge rst_n) begin
				if (!rst_n) begin
					ls_r     <= 1'b0;
					ls_blk_r <= 1'b0;
				end else if (!cfg_i[g].ls_drv_en || st_r != bsc_pkg::ST_OFF) begin
					ls_r     <= 1'b0;
					ls_blk_r <= 1'b0;
				end else if (cmp_i[g].low_out_active && !cfg_i[g].low_out_keep) begin
					ls_r <= 1'b0;
				end else if (ls_r && cmp_i[g].zero_cross && !cfg_i[g].rev_no_limit) begin
					ls_r     <= 1'b0;
					ls_blk_r <= 1'b1;
				end else if (!ls_r && !ls_blk_r && cmp_i[g].hs_gate_thr &&
						(cmp_i[g].zero_cross || cmp_i[g].hs_gate_thr)) begin
					ls_r <= 1'b1;
				end
			end
			assign ls_on_o[g] = ls_r;
			assign hs_on_o[g] = (st_r == bsc_pkg::ST_ON && !ls_r) ||
				cmp_i[g].sw_overvolt;

			// ------------------------------------------------------------
			// overcurrent
			// ------------------------------------------------------------
			always_ff @(posedge clk_sys_i or negedge rst_n) begin
				if (!rst_n) begin
					dim_prev_r   <= 1'b0;
					oc_cnt_r     <= 3'h0;
					oc_seen_r    <= 1'b0;
					oc_latched_r <= 1'b0;
				end else begin
					dim_prev_r <= dim_dly;
					if (st_r == bsc_pkg::ST_ON && cmp_i[g].overcurrent)
						oc_seen_r <= 1'b1;
					else if (st_r == bsc_pkg::ST_OFF)
						oc_seen_r <= 1'b0;
					if (!chan_en_i[g] || (dim_dly && !dim_prev_r))
						oc_cnt_r <= 3'h0;
					else if (st_r == bsc_pkg::ST_ON && st_nxt == bsc_pkg::ST_OFF &&
							(oc_seen_r || cmp_i[g].overcurrent) &&
							oc_cnt_r != ({1'b0, cfg_i[g].oc_limit} + 3'h1))
						oc_cnt_r <= oc_cnt_r + 3'h1;
					// set wins over a read in the same cycle; a later read releases
					if (oc_cnt_r == ({1'b0, cfg_i[g].oc_limit} + 3'h1) && !oc_latched_r)
						oc_latched_r <= 1'b1;
					else if (oc_flag_read_i[g] && oc_latched_r) begin
						oc_latched_r <= 1'b0;
						oc_cnt_r     <= 3'h0;
					end
				end
			end
		end
	endgenerate

	assign lead_peak    = (g_ch[0].st_r == bsc_pkg::ST_ON) && g_ch[0].st_nxt == bsc_pkg::ST_OFF;
	assign lead_off_end = (g_ch[0].st_r == bsc_pkg::ST_OFF) && g_ch[0].st_nxt != bsc_pkg::ST_OFF;
endmodule

// >>> verif/bsc_properties.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checks on channel 0
// ----------------------------------------
module bsc_properties #(
	parameter int NCH       = 2,
	parameter int DELAY_CYC = 8
) (
	input wire logic                        clk_sys_i,
	input wire logic                        rstn_i,
	input wire logic [NCH-1:0]              dim_input_i,
	input wire bsc_pkg::bsc_cfg_s [NCH-1:0] cfg_i,
	input wire bsc_pkg::bsc_cmp_s [NCH-1:0] cmp_i,
	input wire logic [NCH-1:0]              thr_write_i,
	input wire logic [NCH-1:0]              oc_flag_read_i,
	input wire logic [NCH-1:0]              hs_on_o,
	input wire logic [NCH-1:0]              ls_on_o,
	input wire logic [NCH-1:0]              overcurrent_flag_o,
	input wire logic [NCH-1:0]              chan_active_o,
	input wire logic [NCH-1:0][2:0]         range_applied_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	sequence s_flag_wait;
		overcurrent_flag_o[0] && !oc_flag_read_i[0];
	endsequence
	ls_gated_a: assert property (!cfg_i[0].ls_drv_en && $past(!cfg_i[0].ls_drv_en) |-> !ls_on_o[0])
		else $error("low side on while disabled");
	ovd_hs_a: assert property (cmp_i[0].sw_overvolt |-> hs_on_o[0])
		else $error("overvoltage did not force high side");
	ls_after_gate_a: assert property ($rose(ls_on_o[0]) |-> $past(cmp_i[0].hs_gate_thr))
		else $error("low side on before high side gate threshold");
	no_cross_a: assert property (!cmp_i[0].sw_overvolt |-> !(hs_on_o[0] && ls_on_o[0]))
		else $error("both switches on");
	latched_off_a: assert property (overcurrent_flag_o[0] |-> !chan_active_o[0])
		else $error("channel runs while latched");
	flag_hold_a: assert property (s_flag_wait |=> overcurrent_flag_o[0])
		else $error("flag dropped without read");
	dim_delay_a: assert property ($rose(chan_active_o[0]) |-> $past(dim_input_i[0], DELAY_CYC))
		else $error("channel started before dim delay");
	range_write_a: assert property ($changed(range_applied_o[0]) |-> $past(thr_write_i[0]))
		else $error("range applied without threshold write");
endmodule

bind bsc_top bsc_properties #(.NCH(NCH), .DELAY_CYC(DELAY_CYC)) u_props (
	.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .dim_input_i(dim_input_i), .cfg_i(cfg_i),
	.cmp_i(cmp_i), .thr_write_i(thr_write_i), .oc_flag_read_i(oc_flag_read_i),
	.hs_on_o(hs_on_o), .ls_on_o(ls_on_o), .overcurrent_flag_o(overcurrent_flag_o),
	.chan_active_o(chan_active_o), .range_applied_o(range_applied_o));

// >>> verif/bsc_power_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// coil and comparators of one channel
// ----------------------------------------
module bsc_power_model (
	input  wire logic         clk_sys_i,
	input  wire logic         hs_on_i,
	input  wire logic         ls_on_i,
	input  wire logic         oc_i,
	input  wire logic         ovd_i,
	output bsc_pkg::bsc_cmp_s cmp_o
);
	logic [7:0] coil_r = 8'h00;
	logic       hs_q_r = 1'b0;
	logic       ls_q_r = 1'b0;
	always_ff @(posedge clk_sys_i) begin
		hs_q_r <= hs_on_i;
		ls_q_r <= ls_on_i;
		coil_r <= hs_on_i ? coil_r + 8'h04 : coil_r - 8'(coil_r != 8'h00);
	end
	// gates lag the drive by a cycle, so no threshold is reported early
	assign cmp_o = '{zero_cross: !hs_on_i && coil_r == 8'h00, hs_gate_thr: !hs_q_r,
		ls_gate_thr: !ls_q_r, peak_reached: coil_r >= 8'h20,
		overcurrent: oc_i && coil_r >= 8'h20, sw_overvolt: ovd_i, low_out_active: 1'b0};
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; \
	$display("BAD %s exp %0h got %0h", nm, e, a); end end
// ----------------------------------------
// bench
// ----------------------------------------
module tb;
	localparam int D = 8;
	logic                    clk_sys_i = 1'b0;
	logic                    rstn_i = 1'b0;
	logic                    lf = 1'b0;
	logic                    hsp;
	logic [1:0]              en, dim, thw, ocr, oc, switch_node_overvoltage_comp, hs, ls, flag, act;
	bsc_pkg::bsc_cfg_s [1:0] cfg;
	bsc_pkg::bsc_cmp_s [1:0] cmp;
	logic [1:0][6:0]         trim;
	logic [1:0][8:0]         code;
	logic [1:0][2:0]         rsel, rapp;
	logic [1:0][23:0]        base, tgt;
	logic [1:0][15:0]        step;
	int                      n_errors = 0, compares = 0, k, c1, c2, nls, nhf;
	always #2 clk_sys_i = ~clk_sys_i;
	bsc_top #(.NCH(2), .DELAY_CYC(D)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.chan_en_i(en), .dim_input_i(dim), .lead_follow_i(lf), .cfg_i(cfg), .cmp_i(cmp),
		.peak_current_trim_i(trim), .peak_threshold_code_i(code), .peak_range_select_i(rsel),
		.thr_write_i(thw), .range_base_i(base), .range_step_i(step), .oc_flag_read_i(ocr),
		.hs_on_o(hs), .ls_on_o(ls), .overcurrent_flag_o(flag), .chan_active_o(act),
		.range_applied_o(rapp), .peak_target_o(tgt));
	for (genvar i = 0; i < 2; i++) begin : g_pm
		bsc_power_model pm (.clk_sys_i(clk_sys_i), .hs_on_i(hs[i]), .ls_on_i(ls[i]),
			.oc_i(oc[i]), .ovd_i(switch_node_overvoltage_comp[i]), .cmp_o(cmp[i]));
	end
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic strobe(int rd);
		tick();
		if (rd) ocr[0] <= 1'b1;
		else thw[0] <= 1'b1;
		tick();
		{thw, ocr} <= '0;
		tick(2);
		@(negedge clk_sys_i);
	endtask
	task automatic wait_act(input logic v, output int c);
		c = 0;
		while (act[0] !== v && c < 100) begin
			@(negedge clk_sys_i);
			c++;
		end
	endtask
	// stops at the latch so the overcurrent count is not blurred
	task automatic run(int n);
		{nls, nhf, hsp} = '0;
		repeat (n) begin
			@(negedge clk_sys_i);
			nls += (ls[0] === 1'b1);
			nhf += (hsp === 1'b1 && hs[0] === 1'b0);
			hsp = hs[0];
			if (flag[0] === 1'b1) break;
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{en, dim, thw, ocr, oc, switch_node_overvoltage_comp} = '0;
		{trim, code, rsel, base, step} = '0;
		cfg[0] = '{1'b1, 1'b0, 1'b0, 2'h0, 2'h1, 12'h010};
		cfg[1] = cfg[0];
		tick(3);
		rstn_i <= 1'b1;
		tick(3);
		base[0] <= 24'h0004b0;
		step[0] <= 16'h000c;
		code[0] <= 9'h005;
		for (k = 0; k < 3; k++) begin
			tick();
			trim[0] <= 7'(k * 63);
			tick(2);
			@(negedge clk_sys_i);
			`CHK("target", 24'(1260 + 8 * (k * 63 - 63)), tgt[0])
		end
		$display("test target done");
		tick();
		rsel[0] <= 3'h3;
		tick(4);
		@(negedge clk_sys_i);
		`CHK("range held", 3'h0, rapp[0])
		strobe(0);
		`CHK("range new", 3'h3, rapp[0])
		$display("test range done");
		tick();
		en <= 2'h3;
		dim[0] <= 1'b1;
		wait_act(1'b1, c1);
		tick(40);
		dim[0] <= 1'b0;
		wait_act(1'b0, c2);
		`CHK("dim rise", 1'b1, c1 >= D && c1 <= D + 2)
		`CHK("dim fall", c1, c2)
		$display("test dim done");
		tick();
		dim[0] <= 1'b1;
		run(200);
		`CHK("ls used", 1'b1, nls > 0)
		tick();
		cfg[0].ls_drv_en <= 1'b0;
		tick(2);
		run(200);
		`CHK("ls off", 0, nls)
		$display("test low side done");
		tick();
		cfg[0].ls_drv_en <= 1'b1;
		oc[0] <= 1'b1;
		run(500);
		`CHK("oc periods", 2, nhf)
		tick();
		oc[0] <= 1'b0;
		tick(50);
		@(negedge clk_sys_i);
		`CHK("oc latched", 2'b10, {flag[0], act[0]})
		strobe(1);
		`CHK("oc released", 2'b01, {flag[0], act[0]})
		$display("test overcurrent done");
		tick();
		{en, dim} <= '0;
		switch_node_overvoltage_comp[0] <= 1'b1;
		tick(D + 4);
		@(negedge clk_sys_i);
		`CHK("ovd hs", 1'b1, hs[0])
		$display("test overvoltage done");
		print_verdict();
	end
	// tests need about 620 cycles; allow over six times that
	initial begin
		#16000;
		n_errors++;
		print_verdict();
	end
endmodule
